/* verilog/actc_pkg.sv */
// Constants and carrier types for the converter timing sequencer.
// Assumes one system clock in which each cycle stands for one CPU half-period.
package actc_pkg;

  // Clock and basic timing unit
  localparam int        CLK_PERIOD_NS = 50;
  localparam int        HALF_PERIOD_NS = 50;
  localparam int        HALF_PERIOD_CYC_INT = (HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] HALF_PERIOD_CYC = 12'(HALF_PERIOD_CYC_INT < 1 ? 1 : HALF_PERIOD_CYC_INT);

  // Conversion clock select codes
  localparam logic [1:0] CC_SEL_24   = 2'h0;
  localparam logic [1:0] CC_SEL_RSVD = 2'h1;
  localparam logic [1:0] CC_SEL_96   = 2'h2;
  localparam logic [1:0] CC_SEL_48   = 2'h3;

  // Conversion clock period in half-periods
  localparam logic [11:0] CC_HP_24 = 12'h018;
  localparam logic [11:0] CC_HP_96 = 12'h060;
  localparam logic [11:0] CC_HP_48 = 12'h030;

  // Sequence lengths
  localparam logic [3:0]  CONV_STEPS   = 4'he;
  localparam logic [3:0]  RESULT_BITS  = 4'ha;
  localparam logic [11:0] LOAD_HP      = 12'h004;
  localparam logic [11:0] SAMPLE_SC    = 12'h002;

  // Clamp codes
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_FULL = 10'h3ff;

  // Reset values
  localparam logic [2:0] STRAP_RST  = 3'h7;
  localparam logic [9:0] RESULT_RST = 10'h000;

  typedef struct packed {
    logic [1:0] conversion_clock_select;
    logic [1:0] sample_clock_select;
  } actc_sel_type;

  typedef struct packed {
    logic       below_ground;
    logic       above_ref;
    logic [9:0] level;
  } actc_analog_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_LOAD
  } actc_state_type;

endpackage : actc_pkg

/* verilog/actc_seq.sv */
// Conversion timing sequencer: sample window, successive approximation, result load.
// Assumes start, selects and analog data come from logic on sys_clk_in; straps are pins.
//
// What this block does
// R1: Conversion clock is 24, 96 or 48 half-periods for codes 00, 10, 11.
// R2: Sample clock is 1, 2, 4 or 8 conversion clocks; window is two.
// R3: Whole conversion lasts 14 conversion clocks plus window plus 4 half-periods.
// R4: Interval covers sample, decision and load; result changes only at its end.
// R5: Input changes after the sample window do not affect the result.
// R6: Below ground gives code 000, above reference gives code 3ff.
// R7: Sample and conversion timing come only from the programmed select fields.
// R8: Either CPU clock edge may trigger internal or bus operations.
// R9: One half-period is the basic unit; timings are whole multiples of it.
// R10: Clock mode is taken from three strap pins held during reset.
// R11: Counters on the CPU clock run from a request to a completion pulse.
// R12: Reserved conversion clock code is refused and yields no timing.
module actc_seq (
  // Clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_in,
  // Conversion request and settings
  input  wire logic                     conv_start_in,
  input  wire actc_pkg::actc_sel_type   sel_in,
  // Analog core side
  input  wire actc_pkg::actc_analog_type analog_in,
  output logic                          sample_out,
  output logic                          cc_strobe_out,
  // Result and status
  output logic                          busy_out,
  output logic                          done_out,
  output logic                          sel_err_out,
  output logic [9:0]                    result_out,
  // Clock mode straps
  input  wire logic [2:0]               clock_mode_strap_pins_in,
  output logic [2:0]                    clock_mode_out
);

  actc_pkg::actc_state_type  state_r;
  actc_pkg::actc_analog_type held_r;
  logic [11:0]               cnt_r;
  logic [11:0]               cc_len_r;
  logic [3:0]                step_r;
  logic [9:0]                sar_r;
  logic [9:0]                result_r;
  logic                      done_r;
  logic                      sel_err_r;
  logic [2:0]                strap_s1_r;
  logic [2:0]                strap_s2_r;
  logic                      strap_grab_r;
  logic [2:0]                clock_mode_r;
  logic                      start_ok;
  logic                      phase_end;
  logic [11:0]               cc_len_nxt;
  logic [11:0]               sample_len_nxt;
  logic [9:0]                trial;
  logic [9:0]                clamped;

  // Conversion clock length from select code
  function automatic logic [11:0] cc_len_f(input logic [1:0] code);
    logic [11:0] hp;
    hp = 12'h000;
    unique case (code)
      actc_pkg::CC_SEL_24: hp = actc_pkg::CC_HP_24;
      actc_pkg::CC_SEL_96: hp = actc_pkg::CC_HP_96;
      actc_pkg::CC_SEL_48: hp = actc_pkg::CC_HP_48;
      actc_pkg::CC_SEL_RSVD: hp = 12'h000;
    endcase
    return 12'(hp * actc_pkg::HALF_PERIOD_CYC);
  endfunction : cc_len_f

  // Selects decoded into lengths here; start_ok and sel_err_r also read the conversion code
  always_comb begin
    cc_len_nxt     = cc_len_f(sel_in.conversion_clock_select);  // R1 R7 R9
    sample_len_nxt = 12'((cc_len_nxt * actc_pkg::SAMPLE_SC) << sel_in.sample_clock_select);  // R2
  end

  assign start_ok  = conv_start_in && (state_r == actc_pkg::ST_IDLE) &&
                     (sel_in.conversion_clock_select != actc_pkg::CC_SEL_RSVD);  // R12
  assign phase_end = (cnt_r == 12'h000);
  assign trial     = sar_r | (10'h200 >> (step_r[3:0]));

  // Sequencer state and phase counter
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r  <= actc_pkg::ST_IDLE;
      cnt_r    <= 12'h000;
      cc_len_r <= 12'h000;
      step_r   <= 4'h0;
    end else begin
      unique case (state_r)
        actc_pkg::ST_IDLE: begin
          if (start_ok) begin  // R11
            state_r  <= actc_pkg::ST_SAMPLE;
            cc_len_r <= cc_len_nxt;
            cnt_r    <= sample_len_nxt - 12'h001;
          end
        end
        actc_pkg::ST_SAMPLE: begin
          if (phase_end) begin
            state_r <= actc_pkg::ST_CONVERT;
            cnt_r   <= cc_len_r - 12'h001;
            step_r  <= 4'h0;
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        actc_pkg::ST_CONVERT: begin
          if (phase_end) begin
            if (step_r == actc_pkg::CONV_STEPS - 4'h1) begin  // R3
              state_r <= actc_pkg::ST_LOAD;
              cnt_r   <= actc_pkg::LOAD_HP - 12'h001;
            end else begin
              step_r <= step_r + 4'h1;
              cnt_r  <= cc_len_r - 12'h001;
            end
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        actc_pkg::ST_LOAD: begin
          if (phase_end) begin
            state_r <= actc_pkg::ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
      endcase
    end
  end

  // Track input only during the sample window
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      held_r <= '0;
    end else if (state_r == actc_pkg::ST_SAMPLE) begin  // R5
      held_r <= analog_in;
    end
  end

  // One bit decided per conversion clock for the first 10 of the 14 steps, MSB first
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sar_r <= 10'h000;
    end else if (state_r == actc_pkg::ST_SAMPLE) begin
      sar_r <= 10'h000;
    end else if (state_r == actc_pkg::ST_CONVERT && phase_end &&
                 step_r < actc_pkg::RESULT_BITS) begin
      if (trial <= held_r.level) begin
        sar_r <= trial;
      end
    end
  end

  always_comb begin
    if (held_r.below_ground) begin
      clamped = actc_pkg::CODE_ZERO;  // R6
    end else if (held_r.above_ref) begin
      clamped = actc_pkg::CODE_FULL;  // R6
    end else begin
      clamped = sar_r;
    end
  end

  // Result loaded only as the interval closes
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_r <= actc_pkg::RESULT_RST;
      done_r   <= 1'b0;
    end else begin
      done_r <= (state_r == actc_pkg::ST_LOAD) && phase_end;  // R11
      if (state_r == actc_pkg::ST_LOAD && phase_end) begin
        result_r <= clamped;  // R4
      end
    end
  end

  // Refused request on reserved code
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_err_r <= 1'b0;
    end else begin
      sel_err_r <= conv_start_in && (state_r == actc_pkg::ST_IDLE) &&
                   (sel_in.conversion_clock_select == actc_pkg::CC_SEL_RSVD);  // R12
    end
  end

  // Strap synchroniser, no reset so it runs while reset is held
  always_ff @(posedge sys_clk_in) begin
    strap_s1_r <= clock_mode_strap_pins_in;
    strap_s2_r <= strap_s1_r;
  end

  // Capture straps on the first edge after reset release
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_grab_r <= 1'b1;
      clock_mode_r <= actc_pkg::STRAP_RST;
    end else begin
      strap_grab_r <= 1'b0;
      if (strap_grab_r) begin
        clock_mode_r <= strap_s2_r;  // R10
      end
    end
  end

  assign busy_out       = (state_r != actc_pkg::ST_IDLE);
  assign sample_out     = (state_r == actc_pkg::ST_SAMPLE);
  assign cc_strobe_out  = (state_r == actc_pkg::ST_CONVERT) && phase_end;  // R8
  assign done_out       = done_r;
  assign sel_err_out    = sel_err_r;
  assign result_out     = result_r;
  assign clock_mode_out = clock_mode_r;

  // Checking helpers
  logic [11:0] busy_len_r;
  logic [11:0] samp_len_r;
  logic [11:0] exp_len_r;
  logic [11:0] exp_samp_r;
  logic [3:0]  strobes_r;
  logic [11:0] gap_r;
  logic [11:0] exp_cc_r;

  // Cycles since the previous step, against the length the select code asks for
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_r    <= 12'h000;
      exp_cc_r <= 12'h000;
    end else begin
      if (start_ok) begin
        if (sel_in.conversion_clock_select == actc_pkg::CC_SEL_96) begin
          exp_cc_r <= actc_pkg::CC_HP_96;
        end else if (sel_in.conversion_clock_select == actc_pkg::CC_SEL_48) begin
          exp_cc_r <= actc_pkg::CC_HP_48;
        end else begin
          exp_cc_r <= actc_pkg::CC_HP_24;
        end
      end
      if (cc_strobe_out) begin
        gap_r <= 12'h001;
      end else begin
        gap_r <= gap_r + 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_len_r <= 12'h000;
      samp_len_r <= 12'h000;
      exp_len_r  <= 12'h000;
      exp_samp_r <= 12'h000;
      strobes_r  <= 4'h0;
    end else begin
      if (start_ok) begin
        busy_len_r <= 12'h000;
        samp_len_r <= 12'h000;
        strobes_r  <= 4'h0;
        exp_samp_r <= sample_len_nxt;
        exp_len_r  <= 12'(sample_len_nxt + 12'(cc_len_nxt * 12'(actc_pkg::CONV_STEPS))
                      + actc_pkg::LOAD_HP);
      end else begin
        if (busy_out) begin
          busy_len_r <= busy_len_r + 12'h001;
        end
        if (sample_out) begin
          samp_len_r <= samp_len_r + 12'h001;
        end
        if (cc_strobe_out) begin
          strobes_r <= strobes_r + 4'h1;
        end
      end
    end
  end

  total_time_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R3
    $fell(busy_out) |-> busy_len_r == exp_len_r)
    else $error("conversion length differs from expected");

  sample_window_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R2
    $fell(sample_out) |-> samp_len_r == exp_samp_r)
    else $error("sample window length wrong");

  cc_period_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R1
    cc_strobe_out && step_r != 4'h0 |-> $past(cnt_r, 1) == 12'h001 && gap_r == exp_cc_r &&
    (cc_len_r == actc_pkg::CC_HP_24 || cc_len_r == actc_pkg::CC_HP_48 ||
     cc_len_r == actc_pkg::CC_HP_96))
    else $error("conversion clock period not a legal length");

  strobe_count_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R11
    done_out |-> strobes_r == actc_pkg::CONV_STEPS)
    else $error("wrong number of conversion clock steps");

  result_stable_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R4
    !done_out |-> $stable(result_out))
    else $error("result changed outside the load");

  hold_frozen_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R5
    state_r == actc_pkg::ST_CONVERT |=> $stable(held_r))
    else $error("held sample changed after sampling");

  clamp_low_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R6
    state_r == actc_pkg::ST_LOAD && phase_end && held_r.below_ground
    |=> result_out == actc_pkg::CODE_ZERO && done_out)
    else $error("under-range input not clamped to zero");

  clamp_high_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R6
    state_r == actc_pkg::ST_LOAD && phase_end && !held_r.below_ground && held_r.above_ref
    |=> result_out == actc_pkg::CODE_FULL)
    else $error("over-range input not clamped to full scale");

  reserved_refused_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R12
    conv_start_in && !busy_out &&
    sel_in.conversion_clock_select == actc_pkg::CC_SEL_RSVD
    |=> !busy_out && sel_err_out)
    else $error("reserved code started a conversion");

  start_taken_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R7
    start_ok |=> sample_out [*2])
    else $error("accepted request did not open the sample window");

  strap_taken_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R10
    strap_grab_r |=> clock_mode_out == $past(strap_s2_r))
    else $error("strap levels not captured after reset");

  fast_conv_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    start_ok && sel_in.conversion_clock_select == actc_pkg::CC_SEL_24 ##[1:400] done_out);
  slow_conv_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    start_ok && sel_in.conversion_clock_select == actc_pkg::CC_SEL_96 &&
    sel_in.sample_clock_select == 2'h3);
  clamp_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    done_out && result_out == actc_pkg::CODE_FULL);
  refused_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    sel_err_out);

endmodule : actc_seq

/* sim/actc_core_model.sv */
// Behavioural analog core: shows a level while sampling and its inverse after the window.
// Assumes the bench sets level and range flags before each request and holds them.
module actc_core_model (
  // Sequencer side
  input  wire logic                      sample_in,
  // Bench control
  input  wire logic [9:0]                level_in,
  input  wire logic [1:0]                flags_in,
  // Core output
  output actc_pkg::actc_analog_type      analog_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Outside the window the input shows the inverted level, so a late capture shows up
  always_comb begin
    analog_out.below_ground = flags_in[1];
    analog_out.above_ref    = flags_in[0];
    analog_out.level        = sample_in ? level_in : ~level_in;
  end
endmodule : actc_core_model

/* sim/adc_conversion_timing_control_test.sv */
// Self-checking bench for the conversion timing sequencer.
// Assumes actc_pkg and actc_seq compiled first; the core model sits on the analog side.
module adc_conversion_timing_control_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic                      sys_clk_in = 1'b0;
  logic                      rst_in = 1'b1;
  logic                      conv_start_in = 1'b0;
  actc_pkg::actc_sel_type    sel_in = '0;
  actc_pkg::actc_analog_type analog_in;
  logic [9:0]                lvl = 10'h000;
  logic [1:0]                flg = 2'h0;
  logic [2:0]                strap = 3'h5;
  logic                      sample_out;
  logic                      cc_strobe_out;
  logic                      busy_out;
  logic                      done_out;
  logic                      sel_err_out;
  logic [9:0]                result_out;
  logic [2:0]                clock_mode_out;
  int                        n_errors = 0;
  int                        num_checks = 0;

  always #25 sys_clk_in = ~sys_clk_in;

  actc_seq dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .conv_start_in(conv_start_in),
    .sel_in(sel_in), .analog_in(analog_in), .sample_out(sample_out),
    .cc_strobe_out(cc_strobe_out), .busy_out(busy_out), .done_out(done_out),
    .sel_err_out(sel_err_out), .result_out(result_out),
    .clock_mode_strap_pins_in(strap), .clock_mode_out(clock_mode_out));

  actc_core_model core (.sample_in(sample_out), .level_in(lvl), .flags_in(flg),
    .analog_out(analog_in));

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_cnt

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // Straps held through reset, then the captured mode must match them
  task automatic reset_check();
    repeat (20) @(negedge sys_clk_in);
    chk_val({busy_out, sample_out, result_out}, 12'h000, "reset outputs");
    chk_val({9'h000, clock_mode_out}, 12'h007, "reset mode");
    rst_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk_val({9'h000, clock_mode_out}, {9'h000, strap}, "strap mode");
  endtask : reset_check

  // Start held high through busy, so repeated requests must be ignored
  task automatic run_conv(input logic [1:0] cc, input logic [1:0] sc,
                          input logic [9:0] lv, input logic [1:0] fl);
    int c, s, t, k, nb, ns, nst, kf, kl, chg;
    logic [9:0] exp, prev;
    c = (cc == 2'h0) ? 24 : (cc == 2'h2) ? 96 : 48;
    s = 2 * c * (1 << sc);
    t = s + 14 * c + 4;
    exp = fl[1] ? 10'h000 : (fl[0] ? 10'h3ff : lv);
    {k, nb, ns, nst, kf, kl, chg} = '0;
    @(negedge sys_clk_in);
    sel_in = '{cc, sc};
    lvl = lv;
    flg = fl;
    conv_start_in = 1'b1;
    prev = result_out;
    do begin
      @(negedge sys_clk_in);
      k++;
      if (busy_out === 1'b1) nb++;
      if (sample_out === 1'b1) ns++;
      if (cc_strobe_out === 1'b1) begin
        nst++;
        if (kf == 0) kf = k;
        kl = k;
      end
      if (busy_out === 1'b1 && result_out !== prev) chg++;
    end while (done_out !== 1'b1 && k < 4000);
    conv_start_in = 1'b0;
    chk_cnt(k, t + 1, "done cycle");
    chk_cnt(nb, t, "busy length");
    chk_cnt(ns, s, "sample window");
    chk_cnt(kf, s + c, "first strobe");
    chk_cnt(kl - kf, 13 * c, "strobe span");
    chk_cnt(nst, 14, "strobe count");
    chk_cnt(chg, 0, "early result");
    chk_val({done_out, busy_out, result_out}, {2'h2, exp}, "result");
  endtask : run_conv

  task automatic run_rsvd();
    @(negedge sys_clk_in);
    sel_in = '{2'h1, 2'h0};
    conv_start_in = 1'b1;
    @(negedge sys_clk_in);
    conv_start_in = 1'b0;
    chk_val({10'h000, sel_err_out, busy_out}, 12'h002, "reserved refusal");
    @(negedge sys_clk_in);
    chk_val({10'h000, sel_err_out, busy_out}, 12'h000, "reserved after");
  endtask : run_rsvd

  initial begin
    reset_check();
    run_conv(2'h0, 2'h0, 10'h2a5, 2'h0);
    run_conv(2'h2, 2'h1, 10'h15a, 2'h0);
    run_conv(2'h3, 2'h2, 10'h3c3, 2'h0);
    run_conv(2'h0, 2'h3, 10'h001, 2'h1);
    run_conv(2'h3, 2'h0, 10'h200, 2'h3);
    run_conv(2'h0, 2'h0, 10'h3fe, 2'h2);
    run_rsvd();
    finish_test();
  end

  // Whole run is near 5100 cycles
  initial begin
    #(20000 * 50);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule : adc_conversion_timing_control_test
